//--- src/interrupt_bank_command_status.sv
// One interrupt bank: init words, control words, status, mask and vectors
`timescale 1ns/100ps
module interrupt_bank_command_status #(
    parameter int NUM_INPUTS = 8
) (
    input  wire logic       i_clock,
    input  wire logic       i_rst,
    input  wire logic [7:0] i_irq_n,
    input  wire logic [4:0] i_sel,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_other_init_two_wr,
    output logic      [7:0] o_rdata,
    output logic            o_int,
    output logic            o_half_level_req
);

    // ----------------------------------------
    // Priority helpers
    // ----------------------------------------
    // Returns {found, level}; the level just after lowest ranks first
    function automatic logic [3:0] prio_pick(input logic [7:0] v, input logic [2:0] low);
        logic [2:0] idx;
        logic [3:0] res;
        res = 4'h0;
        for (int i = 8; i >= 1; i--)
        begin
            idx = low + 3'(i);
            if (v[idx])
                res = {1'b1, idx};
        end
        return res;
    endfunction

    function automatic logic [2:0] rank(input logic [2:0] lvl, input logic [2:0] low);
        return 3'(lvl - low - 3'h1);
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    irq_bank_pkg::init_state_t state_r;
    logic [7:0] sync1_r;
    logic [7:0] sync2_r;
    logic [7:0] prev_r;
    logic [7:0] pending_r;
    logic [7:0] in_service_r;
    logic [7:0] mask_r;
    logic [7:0] init_two_r;
    logic [7:0] vector_store_r [NUM_INPUTS];
    logic [2:0] lowest_r;
    logic       trigger_level_r;
    logic       cascade_r;
    logic       need_four_r;
    logic       auto_eoi_r;
    logic       full_nest_r;
    logic       rotate_auto_r;
    logic       special_mask_r;
    logic       read_isr_r;
    logic       poll_pend_r;

    logic [7:0] req_lvl;
    logic       wr_init_one;
    logic       wr_op_two;
    logic       wr_op_three;
    logic       poll_read;
    logic [3:0] req_top;
    logic [3:0] isr_top;
    logic       int_now;
    logic [7:0] eligible;
    logic [2:0] vec_idx;
    logic       vec_hit;

    // Pins are active low; invert after synchroniser
    assign req_lvl     = ~sync2_r;
    assign wr_init_one = i_wr && (i_sel == irq_bank_pkg::SEL_INIT_ONE);
    assign wr_op_two   = i_wr && (i_sel == irq_bank_pkg::SEL_OP_TWO) && (state_r == irq_bank_pkg::ST_READY);
    assign wr_op_three = i_wr && (i_sel == irq_bank_pkg::SEL_OP_THREE) && (state_r == irq_bank_pkg::ST_READY);
    assign poll_read   = i_rd && (i_sel == irq_bank_pkg::SEL_OP_THREE) && poll_pend_r;
    assign vec_hit     = (i_sel >= irq_bank_pkg::SEL_VECTOR) && (i_sel < 5'(irq_bank_pkg::SEL_VECTOR + NUM_INPUTS));
    assign vec_idx     = 3'(i_sel - irq_bank_pkg::SEL_VECTOR);

    assign eligible = pending_r & ~mask_r & (special_mask_r ? ~in_service_r : 8'hff);
    assign req_top  = prio_pick(eligible, lowest_r);
    assign isr_top  = prio_pick(in_service_r, lowest_r);
    // Special mask lets lower levels through while one is in service
    assign int_now  = req_top[3] && (special_mask_r || !isr_top[3]
                      || (rank(req_top[2:0], lowest_r) < rank(isr_top[2:0], lowest_r))
                      || (full_nest_r && req_top[2:0] == isr_top[2:0]));

    // ----------------------------------------
    // Input synchroniser
    // ----------------------------------------
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            sync1_r <= 8'hff;
            sync2_r <= 8'hff;
        end
        else
        begin
            sync1_r <= i_irq_n;
            sync2_r <= sync1_r;
        end
    end

    // ----------------------------------------
    // Initialisation sequence
    // ----------------------------------------
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_r         <= irq_bank_pkg::ST_UNINIT;
            trigger_level_r <= 1'b0;
            cascade_r       <= 1'b0;
            need_four_r     <= 1'b0;
            auto_eoi_r      <= 1'b0;
            full_nest_r     <= 1'b0;
            init_two_r      <= irq_bank_pkg::BYTE_ZERO;
        end
        else if (wr_init_one)
        begin
            state_r         <= irq_bank_pkg::ST_WAIT_TWO;
            trigger_level_r <= i_wdata[irq_bank_pkg::B_TRIGGER_MODE];
            cascade_r       <= !i_wdata[irq_bank_pkg::B_SINGLE_BANK];
            need_four_r     <= i_wdata[irq_bank_pkg::B_FOURTH_WORD_NEEDED];
            auto_eoi_r      <= 1'b0;
            full_nest_r     <= 1'b0;
        end
        else if (i_wr)
        begin
            case (state_r)
                irq_bank_pkg::ST_WAIT_TWO:
                    if (i_sel == irq_bank_pkg::SEL_INIT_TWO)
                    begin
                        init_two_r <= i_wdata;
                        if (cascade_r)
                            state_r <= irq_bank_pkg::ST_WAIT_THREE;
                        else if (need_four_r)
                            state_r <= irq_bank_pkg::ST_WAIT_FOUR;
                        else
                            state_r <= irq_bank_pkg::ST_READY;
                    end
                irq_bank_pkg::ST_WAIT_THREE:
                    if (i_sel == irq_bank_pkg::SEL_INIT_THREE)
                        state_r <= need_four_r ? irq_bank_pkg::ST_WAIT_FOUR : irq_bank_pkg::ST_READY;
                irq_bank_pkg::ST_WAIT_FOUR:
                    if (i_sel == irq_bank_pkg::SEL_INIT_FOUR)
                    begin
                        auto_eoi_r  <= i_wdata[irq_bank_pkg::B_AUTO_END_OF_IRQ];
                        full_nest_r <= i_wdata[irq_bank_pkg::B_SPECIAL_FULL_NEST];
                        state_r     <= irq_bank_pkg::ST_READY;
                    end
                default:
                    state_r <= state_r;
            endcase
        end
    end

    // ----------------------------------------
    // Level 1.5 request on second init word
    // ----------------------------------------
    // Set wins over a readback in the same cycle
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            o_half_level_req <= 1'b0;
        else if ((i_wr && i_sel == irq_bank_pkg::SEL_INIT_TWO) || i_other_init_two_wr)
            o_half_level_req <= 1'b1;
        else if (i_rd && i_sel == irq_bank_pkg::SEL_INIT_TWO)
            o_half_level_req <= 1'b0;
    end

    // ----------------------------------------
    // Pending requests
    // ----------------------------------------
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            pending_r <= irq_bank_pkg::BYTE_ZERO;
            prev_r    <= irq_bank_pkg::BYTE_ZERO;
        end
        else if (wr_init_one)
        begin
            // In edge mode a held request must make a fresh edge after init
            pending_r <= irq_bank_pkg::BYTE_ZERO;
            prev_r    <= req_lvl;
        end
        else if (poll_read)
        begin
            if (int_now && !trigger_level_r)
                pending_r[req_top[2:0]] <= 1'b0;
        end
        else if (!poll_pend_r)
        begin
            prev_r <= req_lvl;
            if (trigger_level_r)
                pending_r <= req_lvl;
            else
                pending_r <= (pending_r | (req_lvl & ~prev_r)) & req_lvl;
        end
    end

    // ----------------------------------------
    // In-service, priority and rotation
    // ----------------------------------------
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            in_service_r  <= irq_bank_pkg::BYTE_ZERO;
            lowest_r      <= irq_bank_pkg::LOWEST_PRIO_RESET;
            rotate_auto_r <= 1'b0;
        end
        else if (wr_init_one)
        begin
            in_service_r  <= irq_bank_pkg::BYTE_ZERO;
            lowest_r      <= irq_bank_pkg::LOWEST_PRIO_RESET;
            rotate_auto_r <= 1'b0;
        end
        else if (poll_read && int_now)
        begin
            if (!auto_eoi_r)
                in_service_r[req_top[2:0]] <= 1'b1;
            else if (rotate_auto_r)
                lowest_r <= req_top[2:0];
        end
        else if (wr_op_two)
        begin
            case (i_wdata[7:5])
                3'b001:
                    if (isr_top[3])
                        in_service_r[isr_top[2:0]] <= 1'b0;
                3'b101:
                    if (isr_top[3])
                    begin
                        in_service_r[isr_top[2:0]] <= 1'b0;
                        lowest_r                   <= isr_top[2:0];
                    end
                3'b011:
                    in_service_r[i_wdata[2:0]] <= 1'b0;
                3'b111:
                begin
                    in_service_r[i_wdata[2:0]] <= 1'b0;
                    lowest_r                   <= i_wdata[2:0];
                end
                3'b110:
                    lowest_r <= i_wdata[2:0];
                3'b100:
                    rotate_auto_r <= 1'b1;
                3'b000:
                    rotate_auto_r <= 1'b0;
                default:
                    rotate_auto_r <= rotate_auto_r;
            endcase
        end
    end

    // ----------------------------------------
    // Mask, special mask and read selection
    // ----------------------------------------
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            mask_r         <= irq_bank_pkg::BYTE_ZERO;
            special_mask_r <= 1'b0;
            read_isr_r     <= 1'b0;
            poll_pend_r    <= 1'b0;
        end
        else if (wr_init_one)
        begin
            mask_r         <= irq_bank_pkg::BYTE_ZERO;
            special_mask_r <= 1'b0;
            read_isr_r     <= 1'b0;
            poll_pend_r    <= 1'b0;
        end
        else
        begin
            // Any order of control words is fine once ready
            if (i_wr && i_sel == irq_bank_pkg::SEL_OP_ONE && state_r == irq_bank_pkg::ST_READY)
                mask_r <= i_wdata;
            if (wr_op_three)
            begin
                if (i_wdata[irq_bank_pkg::B_SPECIAL_MASK_ENABLE])
                    special_mask_r <= i_wdata[irq_bank_pkg::B_SPECIAL_MASK_SELECT];
                if (i_wdata[irq_bank_pkg::B_READ_REGISTER])
                    read_isr_r <= i_wdata[irq_bank_pkg::B_READ_SELECT];
                poll_pend_r <= i_wdata[irq_bank_pkg::B_POLL];
            end
            else if (poll_read)
                poll_pend_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // Vector registers
    // ----------------------------------------
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            for (int k = 0; k < NUM_INPUTS; k++)
                vector_store_r[k] <= irq_bank_pkg::BYTE_ZERO;
        end
        else if (i_wr && vec_hit)
            vector_store_r[vec_idx] <= i_wdata;
    end

    // ----------------------------------------
    // Read data and request output
    // ----------------------------------------
    // Read answers on the edge after the strobe
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_rdata <= irq_bank_pkg::BYTE_ZERO;
            o_int   <= 1'b0;
        end
        else
        begin
            o_int <= int_now && (state_r == irq_bank_pkg::ST_READY) && !poll_pend_r;
            if (i_rd)
            begin
                if (i_sel == irq_bank_pkg::SEL_OP_THREE)
                begin
                    if (poll_pend_r)
                        o_rdata <= {int_now, 4'h0, req_top[2:0]};
                    else if (read_isr_r)
                        o_rdata <= in_service_r;
                    else
                        o_rdata <= pending_r;
                end
                else if (i_sel == irq_bank_pkg::SEL_OP_ONE)
                    o_rdata <= mask_r;
                else if (i_sel == irq_bank_pkg::SEL_INIT_TWO)
                    o_rdata <= init_two_r;
                else if (vec_hit)
                    o_rdata <= vector_store_r[vec_idx];
                else
                    o_rdata <= irq_bank_pkg::BYTE_ZERO;
            end
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_half_level_raise: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_wr && i_sel == irq_bank_pkg::SEL_INIT_TWO) |=> o_half_level_req)
        else $error("level 1.5 request not raised");

    a_half_level_clear: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_rd && i_sel == irq_bank_pkg::SEL_INIT_TWO && !i_wr && !i_other_init_two_wr) |=> !o_half_level_req)
        else $error("level 1.5 request not cleared by readback");

    a_mask_readback: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_rd && i_sel == irq_bank_pkg::SEL_OP_ONE) |=> (o_rdata == $past(mask_r)))
        else $error("mask read differs from stored mask");

    a_poll_override: assert property (@(posedge i_clock) disable iff (i_rst)
        (wr_op_three && i_wdata[irq_bank_pkg::B_POLL] && i_wdata[irq_bank_pkg::B_READ_REGISTER])
        |=> poll_pend_r)
        else $error("status read not replaced by poll result");

    a_poll_one_shot: assert property (@(posedge i_clock) disable iff (i_rst)
        (poll_read && !i_wr) |=> !poll_pend_r)
        else $error("poll stayed armed after its read");

    a_poll_ack_isr: assert property (@(posedge i_clock) disable iff (i_rst)
        (poll_read && int_now && !auto_eoi_r && !i_wr) |=> in_service_r[$past(req_top[2:0])])
        else $error("poll read did not set in-service bit");

    a_poll_freeze: assert property (@(posedge i_clock) disable iff (i_rst)
        (poll_pend_r && !poll_read && !wr_init_one) |=> $stable(pending_r))
        else $error("requests changed while poll pending");

    a_smm_ignored: assert property (@(posedge i_clock) disable iff (i_rst)
        (wr_op_three && !i_wdata[irq_bank_pkg::B_SPECIAL_MASK_ENABLE]) |=> $stable(special_mask_r))
        else $error("special mask changed without enable");

    a_specific_eoi: assert property (@(posedge i_clock) disable iff (i_rst)
        (wr_op_two && i_wdata[7:5] == 3'b011) |=> !in_service_r[$past(i_wdata[2:0])])
        else $error("specific end-of-interrupt left bit set");

    a_read_select: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_rd && i_sel == irq_bank_pkg::SEL_OP_THREE && !poll_pend_r && read_isr_r)
        |=> (o_rdata == $past(in_service_r)))
        else $error("in-service view not returned");

endmodule

//--- src/irq_bank_pkg.sv
// Constants for one interrupt bank: register selects, bit fields, reset values
package irq_bank_pkg;

    // ----------------------------------------
    // Register selects
    // ----------------------------------------
    localparam logic [4:0] SEL_INIT_ONE   = 5'h00;
    localparam logic [4:0] SEL_INIT_TWO   = 5'h01;
    localparam logic [4:0] SEL_INIT_THREE = 5'h02;
    localparam logic [4:0] SEL_INIT_FOUR  = 5'h03;
    localparam logic [4:0] SEL_OP_ONE     = 5'h04;
    localparam logic [4:0] SEL_OP_TWO     = 5'h05;
    localparam logic [4:0] SEL_OP_THREE   = 5'h06;
    localparam logic [4:0] SEL_VECTOR     = 5'h08;

    // ----------------------------------------
    // Bit positions
    // ----------------------------------------
    localparam int B_FOURTH_WORD_NEEDED  = 0;
    localparam int B_SINGLE_BANK         = 1;
    localparam int B_TRIGGER_MODE        = 3;
    localparam int B_AUTO_END_OF_IRQ     = 1;
    localparam int B_SPECIAL_FULL_NEST   = 4;
    localparam int B_END_OF_IRQ          = 5;
    localparam int B_LEVEL_SELECT        = 6;
    localparam int B_ROTATE              = 7;
    localparam int B_READ_SELECT         = 0;
    localparam int B_READ_REGISTER       = 1;
    localparam int B_POLL                = 2;
    localparam int B_SPECIAL_MASK_SELECT = 5;
    localparam int B_SPECIAL_MASK_ENABLE = 6;
    localparam int B_POLL_FOUND          = 7;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [2:0] LOWEST_PRIO_RESET = 3'h7;
    localparam logic [7:0] BYTE_ZERO         = 8'h00;

    typedef enum logic [4:0] {
        ST_UNINIT    = 5'b00001,
        ST_WAIT_TWO  = 5'b00010,
        ST_WAIT_THREE= 5'b00100,
        ST_WAIT_FOUR = 5'b01000,
        ST_READY     = 5'b10000
    } init_state_t;

endpackage

//--- testbench/host_model.sv
// Host processor model issuing register writes and reads to the bank
`timescale 1ns/100ps
module host_model (
    input  wire logic       i_clock,
    input  wire logic [7:0] i_rdata,
    output logic      [4:0] o_sel,
    output logic            o_wr,
    output logic            o_rd,
    output logic      [7:0] o_wdata
);
    initial
    begin
        o_sel   = 5'h1f;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
        o_wdata = 8'h00;
    end

    // ----------------------------------------
    // Bus cycles
    // ----------------------------------------
    // Released bus shows inverted values, never a stale copy
    task automatic write(input logic [4:0] sel, input logic [7:0] data);
        @(posedge i_clock);
        o_sel   <= sel;
        o_wdata <= data;
        o_wr    <= 1'b1;
        @(posedge i_clock);
        o_wr    <= 1'b0;
        o_sel   <= ~sel;
        o_wdata <= ~data;
    endtask

    // Read data is registered, so it is taken just after the strobe edge
    task automatic read(input logic [4:0] sel, output logic [7:0] data);
        @(posedge i_clock);
        o_sel <= sel;
        o_rd  <= 1'b1;
        @(posedge i_clock);
        o_rd  <= 1'b0;
        o_sel <= ~sel;
        #1;
        data = i_rdata;
    endtask
endmodule

//--- testbench/tb.sv
// Self-checking bench for the interrupt bank command and status path
`timescale 1ns/100ps
module tb;
    logic        i_clock;
    logic        i_rst;
    logic [7:0]  i_irq_n;
    logic        i_other_init_two_wr;
    logic [4:0]  sel;
    logic        wr;
    logic        rd;
    logic [7:0]  wdata;
    logic [7:0]  o_rdata;
    logic        o_int;
    logic        o_half_level_req;
    int          mismatches;
    int          checks_done;
    logic [15:0] lfsr_r;
    logic [7:0]  rv;
    logic [7:0]  pat;
    logic [7:0]  e;
    logic [2:0]  lvl;
    logic [7:0]  vexp [8];

    interrupt_bank_command_status #(.NUM_INPUTS(8)) u_dut (
        .i_clock(i_clock), .i_rst(i_rst), .i_irq_n(i_irq_n), .i_sel(sel), .i_wr(wr), .i_rd(rd),
        .i_wdata(wdata), .i_other_init_two_wr(i_other_init_two_wr), .o_rdata(o_rdata),
        .o_int(o_int), .o_half_level_req(o_half_level_req));

    host_model u_host (
        .i_clock(i_clock), .i_rdata(o_rdata), .o_sel(sel), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));

    initial
    begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic rnd();
        lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
        rv = lfsr_r[7:0];
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
            mismatches++;
        end
    endtask

    task automatic rc(input logic [4:0] s, input logic [7:0] exp, input string what);
        logic [7:0] d;
        u_host.read(s, d);
        chk(d, exp, what);
    endtask

    task automatic pins(input logic [7:0] p);
        @(posedge i_clock);
        i_irq_n <= ~p;
        repeat (4) @(posedge i_clock);
    endtask

    // Highest requesting level, searching upward from the one after the lowest
    function automatic logic [7:0] poll_exp(input logic [7:0] p, input logic [2:0] low);
        logic [2:0] l;
        for (int k = 1; k <= 8; k++)
        begin
            l = low + 3'(k);
            if (p[l])
                return {5'h10, l};
        end
        return 8'h00;
    endfunction

    task automatic init_bank(input logic [7:0] one, input logic [7:0] four);
        u_host.write(irq_bank_pkg::SEL_INIT_ONE, one);
        u_host.write(irq_bank_pkg::SEL_INIT_TWO, 8'h5a);
        u_host.write(irq_bank_pkg::SEL_INIT_FOUR, four);
        chk({7'h00, o_half_level_req}, 8'h01, "half request raised");
        rc(irq_bank_pkg::SEL_INIT_TWO, 8'h5a, "init two readback");
        @(posedge i_clock);
        chk({7'h00, o_half_level_req}, 8'h00, "half request cleared");
    endtask

    task automatic summarize();
        if (mismatches == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        mismatches = 0;
        checks_done = 0;
        lfsr_r = 16'h02fa;
        i_rst = 1'b1;
        i_irq_n = 8'hff;
        i_other_init_two_wr = 1'b0;
        repeat (8) @(posedge i_clock);
        chk({o_rdata[6:0], o_int}, 8'h00, "outputs in reset");
        i_rst <= 1'b0;
        // Vectors go in before init so the level 1.5 service is ready
        for (int i = 0; i < 8; i++)
        begin
            rnd();
            vexp[i] = rv;
            u_host.write(irq_bank_pkg::SEL_VECTOR + 5'(i), rv);
        end
        for (int i = 0; i < 8; i++)
            rc(irq_bank_pkg::SEL_VECTOR + 5'(i), vexp[i], "vector readback");
        init_bank(8'h0b, 8'h00);
        @(posedge i_clock);
        i_other_init_two_wr <= 1'b1;
        @(posedge i_clock);
        i_other_init_two_wr <= 1'b0;
        repeat (2) @(posedge i_clock);
        chk({7'h00, o_half_level_req}, 8'h01, "other bank half request");
        rc(irq_bank_pkg::SEL_INIT_TWO, 8'h5a, "init two readback");
        rnd();
        u_host.write(irq_bank_pkg::SEL_OP_ONE, rv);
        rc(irq_bank_pkg::SEL_OP_ONE, rv, "mask readback");
        u_host.write(irq_bank_pkg::SEL_OP_ONE, 8'h00);
        rnd();
        pat = rv | 8'h10;
        pins(pat);
        u_host.write(irq_bank_pkg::SEL_OP_THREE, 8'h02);
        rc(irq_bank_pkg::SEL_OP_THREE, pat, "pending view");
        rc(irq_bank_pkg::SEL_OP_THREE, pat, "pending view kept");
        chk({7'h00, o_int}, 8'h01, "request out");
        u_host.write(irq_bank_pkg::SEL_OP_THREE, 8'h03);
        rc(irq_bank_pkg::SEL_OP_THREE, 8'h00, "in-service empty");
        u_host.write(irq_bank_pkg::SEL_OP_THREE, 8'h07);
        e = poll_exp(pat, 3'h7);
        lvl = e[2:0];
        rc(irq_bank_pkg::SEL_OP_THREE, e, "poll over status read");
        rc(irq_bank_pkg::SEL_OP_THREE, 8'h01 << lvl, "poll acknowledged");
        u_host.write(irq_bank_pkg::SEL_OP_TWO, {5'b01100, lvl});
        rc(irq_bank_pkg::SEL_OP_THREE, 8'h00, "specific clear");
        u_host.write(irq_bank_pkg::SEL_OP_THREE, 8'h04);
        rc(irq_bank_pkg::SEL_OP_THREE, e, "poll again");
        u_host.write(irq_bank_pkg::SEL_OP_TWO, 8'h20);
        rc(irq_bank_pkg::SEL_OP_THREE, 8'h00, "nonspecific clear");
        // Rotation on both clear kinds moves the served level to lowest
        for (int c = 0; c < 2; c++)
        begin
            u_host.write(irq_bank_pkg::SEL_OP_THREE, 8'h04);
            rc(irq_bank_pkg::SEL_OP_THREE, e, "poll before rotate");
            u_host.write(irq_bank_pkg::SEL_OP_TWO, (c == 0 ? 8'ha0 : 8'he0) | {5'h00, lvl});
            rc(irq_bank_pkg::SEL_OP_THREE, 8'h00, "rotate clear");
            e = poll_exp(pat, lvl);
            lvl = e[2:0];
        end
        rnd();
        u_host.write(irq_bank_pkg::SEL_OP_TWO, {5'b11000, rv[2:0]});
        u_host.write(irq_bank_pkg::SEL_OP_THREE, 8'h04);
        rc(irq_bank_pkg::SEL_OP_THREE, poll_exp(pat, rv[2:0]), "set priority poll");
        u_host.write(irq_bank_pkg::SEL_OP_TWO, 8'h20);
        init_bank(8'h03, 8'h02);
        u_host.write(irq_bank_pkg::SEL_OP_THREE, 8'h02);
        rc(irq_bank_pkg::SEL_OP_THREE, 8'h00, "edge needs transition");
        pins(8'h00);
        pins(pat);
        rc(irq_bank_pkg::SEL_OP_THREE, pat, "edge pending");
        u_host.write(irq_bank_pkg::SEL_OP_THREE, 8'h04);
        e = poll_exp(pat, 3'h7);
        rc(irq_bank_pkg::SEL_OP_THREE, e, "poll after reinit");
        u_host.write(irq_bank_pkg::SEL_OP_THREE, 8'h03);
        rc(irq_bank_pkg::SEL_OP_THREE, 8'h00, "auto clear in service");
        // Rotate in auto clear mode: served level becomes lowest
        pat = pat & ~(8'h01 << e[2:0]);
        u_host.write(irq_bank_pkg::SEL_OP_TWO, 8'h80);
        u_host.write(irq_bank_pkg::SEL_OP_THREE, 8'h04);
        e = poll_exp(pat, 3'h7);
        rc(irq_bank_pkg::SEL_OP_THREE, e, "poll auto rotate");
        lvl = e[7] ? e[2:0] : 3'h7;
        pat = pat & ~(8'h01 << e[2:0]);
        u_host.write(irq_bank_pkg::SEL_OP_THREE, 8'h04);
        rc(irq_bank_pkg::SEL_OP_THREE, poll_exp(pat, lvl), "poll after auto rotate");
        summarize();
    end

    initial
    begin
        #(20 * 20000);
        mismatches++;
        summarize();
    end
endmodule
